//--- nvc_flash_ctrl.sv
/*
  flash write/erase controller with code flash and user config arrays.
  assumes an Avalon-MM master on the register port and a processor
  memory port on the same clock that holds a request until FL_WAIT is low.
*/
`timescale 1ns/100ps
`default_nettype none
module nvc_flash_ctrl
  import nvc_pkg::*;
#(
  parameter int PAGES = 48,
  parameter int PAGE_WORDS = 1024,
  parameter int UCFG_WORDS = 64,
  parameter int ADDR_W = 19,
  parameter int PAGE_ERASE_CYCLES = NVC_PAGE_ERASE_CYCLES,
  parameter int FULL_ERASE_CYCLES = NVC_FULL_ERASE_CYCLES
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register bus
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // processor flash port
  input wire logic [ADDR_W-1:0] FL_ADDR,
  input wire logic FL_READ,
  input wire logic FL_WRITE,
  input wire logic FL_FETCH,
  input wire logic [31:0] FL_WDATA,
  input wire logic [3:0] FL_BYTEENABLE,
  output logic [31:0] FL_RDATA,
  output logic FL_WAIT,
  output logic FL_FAULT,
  // configuration taken from the user area at reset
  output logic [31:0] USER_CFG_WORD
);

  localparam int CODE_WORDS = PAGES * PAGE_WORDS;
  localparam int IDX_W = ADDR_W - 3;
  localparam int PROG_CNT = NVC_WORD_PROGRAM_CYCLES - 1;
  localparam int PAGE_CNT = PAGE_ERASE_CYCLES - 1;
  localparam int FULL_CNT = FULL_ERASE_CYCLES - 1;

  // elaboration-time refusal of sizes the logic cannot serve
  if (ADDR_W < 4 || CODE_WORDS * 4 > (1 << (ADDR_W - 1)) ||
      UCFG_WORDS * 4 > (1 << (ADDR_W - 1)))
  begin : g_fit_chk
    $error("flash arrays do not fit the address width");
  end
  if (PAGE_ERASE_CYCLES < 1 || FULL_ERASE_CYCLES < 1 || PAGES < 1 || PAGE_WORDS < 1 ||
      UCFG_WORDS < 1)
  begin : g_cnt_chk
    $error("counts must be at least one");
  end

  function automatic logic idx_ok(input logic user, input logic [IDX_W-1:0] idx);
    if (user)
      idx_ok = 32'(idx) < UCFG_WORDS;
    else
      idx_ok = 32'(idx) < CODE_WORDS;
  endfunction

  logic [31:0] code_mem [CODE_WORDS];
  logic [31:0] user_mem [UCFG_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // state
  nvc_state_t state_q, state_d;
  nvc_kind_t kind_q, kind_d;
  logic [31:0] cnt_q, cnt_d;
  logic [IDX_W-1:0] tgt_q, tgt_d;
  logic tgt_user_q, tgt_user_d;
  logic [31:0] pdata_q, pdata_d;
  logic [1:0] mode_q, mode_d;
  logic av_ack_q, av_ack_d;
  logic [31:0] av_rdata_q, av_rdata_d;
  logic fl_rack_q, fl_rack_d;
  logic fl_wack_q, fl_wack_d;
  logic [31:0] fl_rdata_q, fl_rdata_d;
  logic fault_q, fault_d;
  logic cfg_taken_q, cfg_taken_d;
  logic [31:0] ucfg_q, ucfg_d;
  logic prog_go, erase_go;

  logic busy;
  logic av_take_wr;
  logic fl_user;
  logic [IDX_W-1:0] fl_idx;
  logic [IDX_W-1:0] page_idx;
  logic [31:0] fl_word;
  logic rd_stall;

  assign busy = state_q != NVC_IDLE;
  assign av_take_wr = AVS_WRITE && av_ack_q;
  assign fl_user = FL_ADDR[ADDR_W-1];
  assign fl_idx = FL_ADDR[ADDR_W-2:2];
  assign page_idx = AVS_WRITEDATA[ADDR_W-2:2];
  assign fl_word = fl_user ? user_mem[32'(fl_idx) % UCFG_WORDS] :
                   code_mem[32'(fl_idx) % CODE_WORDS];
  // programming stalls all reads, erase stalls only fetch reads
  assign rd_stall = (state_q == NVC_PROG) || (state_q == NVC_ERASE && FL_FETCH);

  // handshake outputs
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !av_ack_q;
  assign FL_WAIT = (FL_READ && !fl_rack_q) || (FL_WRITE && !fl_wack_q);
  assign AVS_READDATA = av_rdata_q;
  assign FL_RDATA = fl_rdata_q;
  assign FL_FAULT = fault_q;
  assign USER_CFG_WORD = ucfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    tgt_d = tgt_q;
    tgt_user_d = tgt_user_q;
    pdata_d = pdata_q;
    mode_d = mode_q;
    av_ack_d = (AVS_READ || AVS_WRITE) && !av_ack_q;
    av_rdata_d = av_rdata_q;
    fl_rack_d = FL_READ && !fl_rack_q && !rd_stall;
    fl_wack_d = 1'b0;
    fl_rdata_d = fl_rdata_q;
    fault_d = 1'b0;
    cfg_taken_d = 1'b1;
    ucfg_d = ucfg_q;
    prog_go = 1'b0;
    erase_go = 1'b0;

    // new user config applies only once, right after reset
    if (!cfg_taken_q)
      ucfg_d = user_mem[0];

    if (AVS_READ && !av_ack_q)
    begin
      case (AVS_ADDRESS)
        NVC_OFS_READY: av_rdata_d = 32'(!busy) << NVC_READY_BIT;
        NVC_OFS_CONFIG: av_rdata_d = 32'(mode_q) << NVC_MODE_LSB;
        default: av_rdata_d = 32'h0;
      endcase
    end

    if (fl_rack_d)
      fl_rdata_d = fl_word;

    // mode changes are taken whenever byte 0 is enabled, even while busy; reserved value 3 enables nothing
    if (av_take_wr && AVS_ADDRESS == NVC_OFS_CONFIG && AVS_BYTEENABLE[0])
      mode_d = AVS_WRITEDATA[NVC_MODE_LSB +: 2];

    case (state_q)
      NVC_IDLE:
      begin
        if (av_take_wr && mode_q == NVC_MODE_EEN && AVS_BYTEENABLE == 4'hf)
        begin
          case (AVS_ADDRESS)
            NVC_OFS_PAGE_ERASE:
            begin
              if (!AVS_WRITEDATA[ADDR_W-1] && idx_ok(1'b0, page_idx))
              begin
                state_d = NVC_ERASE;
                kind_d = NVC_K_PAGE;
                tgt_d = page_idx;
                cnt_d = 32'(PAGE_CNT);
              end
            end
            NVC_OFS_USER_ERASE:
            begin
              if (AVS_WRITEDATA[0])
              begin
                state_d = NVC_ERASE;
                kind_d = NVC_K_USER;
                cnt_d = 32'(PAGE_CNT);
              end
            end
            NVC_OFS_FULL_ERASE:
            begin
              if (AVS_WRITEDATA[0])
              begin
                state_d = NVC_ERASE;
                kind_d = NVC_K_ALL;
                cnt_d = 32'(FULL_CNT);
              end
            end
            default:
            begin
              state_d = NVC_IDLE;
            end
          endcase
        end
        else if (FL_WRITE && !fl_wack_q)
        begin
          if (FL_ADDR[1:0] != 2'h0 || FL_BYTEENABLE != 4'hf)
          begin
            fault_d = 1'b1;
            fl_wack_d = 1'b1;
          end
          else if (mode_q != NVC_MODE_WEN || !idx_ok(fl_user, fl_idx))
            fl_wack_d = 1'b1;
          else
          begin
            state_d = NVC_PROG;
            tgt_d = fl_idx;
            tgt_user_d = fl_user;
            pdata_d = FL_WDATA;
            cnt_d = 32'(PROG_CNT);
          end
        end
      end
      NVC_PROG:
      begin
        if (cnt_q == 32'h0)
        begin
          prog_go = 1'b1;
          fl_wack_d = 1'b1;
          state_d = NVC_IDLE;
        end
        else
          cnt_d = cnt_q - 32'h1;
      end
      NVC_ERASE:
      begin
        if (cnt_q == 32'h0)
        begin
          erase_go = 1'b1;
          state_d = NVC_IDLE;
        end
        else
          cnt_d = cnt_q - 32'h1;
      end
      default:
      begin
        state_d = NVC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= NVC_IDLE;
      kind_q <= NVC_K_PAGE;
      cnt_q <= 32'h0;
      tgt_q <= '0;
      tgt_user_q <= 1'b0;
      pdata_q <= 32'h0;
      mode_q <= NVC_MODE_RESET;
      av_ack_q <= 1'b0;
      av_rdata_q <= 32'h0;
      fl_rack_q <= 1'b0;
      fl_wack_q <= 1'b0;
      fl_rdata_q <= 32'h0;
      fault_q <= 1'b0;
      cfg_taken_q <= 1'b0;
      ucfg_q <= 32'h0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      tgt_q <= tgt_d;
      tgt_user_q <= tgt_user_d;
      pdata_q <= pdata_d;
      mode_q <= mode_d;
      av_ack_q <= av_ack_d;
      av_rdata_q <= av_rdata_d;
      fl_rack_q <= fl_rack_d;
      fl_wack_q <= fl_wack_d;
      fl_rdata_q <= fl_rdata_d;
      fault_q <= fault_d;
      cfg_taken_q <= cfg_taken_d;
      ucfg_q <= ucfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile arrays, no reset
  always_ff @(posedge CLK)
  begin
    if (prog_go)
    begin
      if (tgt_user_q)
        user_mem[32'(tgt_q) % UCFG_WORDS] <= user_mem[32'(tgt_q) % UCFG_WORDS] & pdata_q;
      else
        code_mem[32'(tgt_q) % CODE_WORDS] <= code_mem[32'(tgt_q) % CODE_WORDS] & pdata_q;
    end
    if (erase_go)
    begin
      // factory info is not held here, so no erase can reach it
      for (int i = 0; i < CODE_WORDS; i++)
      begin
        if (kind_q == NVC_K_ALL || (kind_q == NVC_K_PAGE && i / PAGE_WORDS ==
            32'(tgt_q) / PAGE_WORDS))
          code_mem[i] <= NVC_ERASED_WORD;
      end
      for (int j = 0; j < UCFG_WORDS; j++)
      begin
        if (kind_q != NVC_K_PAGE)
          user_mem[j] <= NVC_ERASED_WORD;
      end
    end
  end

endmodule
`default_nettype wire

//--- nvc_pkg.sv
/*
  constants, types and timing for the flash write/erase controller.
  assumes a 25 MHz system clock and byte addresses on the register bus.
*/
package nvc_pkg;

  // register byte offsets
  localparam logic [11:0] NVC_OFS_READY = 12'h400;
  localparam logic [11:0] NVC_OFS_CONFIG = 12'h504;
  localparam logic [11:0] NVC_OFS_PAGE_ERASE = 12'h508;
  localparam logic [11:0] NVC_OFS_FULL_ERASE = 12'h50c;
  localparam logic [11:0] NVC_OFS_USER_ERASE = 12'h514;

  // field positions and reset values
  localparam int NVC_READY_BIT = 0;
  localparam int NVC_MODE_LSB = 0;
  localparam logic [1:0] NVC_MODE_RESET = 2'h0;
  localparam logic NVC_READY_RESET = 1'b1;
  localparam logic [31:0] NVC_ERASED_WORD = 32'hffffffff;

  // access modes
  localparam logic [1:0] NVC_MODE_RO = 2'h0;
  localparam logic [1:0] NVC_MODE_WEN = 2'h1;
  localparam logic [1:0] NVC_MODE_EEN = 2'h2;

  // timing
  localparam int NVC_CLK_MHZ = 25;
  localparam int NVC_WORD_PROGRAM_TIME_US = 50;
  localparam int NVC_PAGE_ERASE_TIME_US = 100000;
  localparam int NVC_FULL_ERASE_TIME_US = 200000;
  localparam int NVC_WORD_PROGRAM_CYCLES = NVC_WORD_PROGRAM_TIME_US * NVC_CLK_MHZ;
  localparam int NVC_PAGE_ERASE_CYCLES = NVC_PAGE_ERASE_TIME_US * NVC_CLK_MHZ;
  localparam int NVC_FULL_ERASE_CYCLES = NVC_FULL_ERASE_TIME_US * NVC_CLK_MHZ;

  typedef enum logic [1:0]
  {
    NVC_IDLE = 2'b00,
    NVC_PROG = 2'b01,
    NVC_ERASE = 2'b10
  } nvc_state_t;

  typedef enum logic [1:0]
  {
    NVC_K_PAGE = 2'h0,
    NVC_K_USER = 2'h1,
    NVC_K_ALL = 2'h2
  } nvc_kind_t;

endpackage

//--- nvc_flash_chk.sv
/* port assertions for nvc_flash_ctrl.
   bound onto the design from the testbench file. */
`timescale 1ns/100ps
`default_nettype none
module nvc_flash_chk
#(
  parameter int ADDR_W = 19
)
(
  // clock, reset, register bus
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // processor port
  input wire logic [ADDR_W-1:0] FL_ADDR,
  input wire logic FL_READ,
  input wire logic FL_WRITE,
  input wire logic FL_FETCH,
  input wire logic [3:0] FL_BYTEENABLE,
  input wire logic FL_WAIT,
  input wire logic FL_FAULT,
  input wire logic [31:0] USER_CFG_WORD
);
  // stall cycles seen by the current write
  logic [11:0] wcnt_q;
  logic [11:0] wcnt_d;
  assign wcnt_d = (FL_WRITE && FL_WAIT) ? wcnt_q + 12'h1 : 12'h0;
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      wcnt_q <= 12'h0;
    else
      wcnt_q <= wcnt_d;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////
  chk_avs_one_wait: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("bus wait");
  chk_ready_bits: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 12'h400 |-> AVS_READDATA[31:1] == 31'h0)
    else $error("ready bits");
  chk_rdata_stands: assert property (
    !$stable(AVS_READDATA) |-> $past(AVS_READ && AVS_WAITREQUEST)) else $error("rdata moved");
  chk_fault_pulse: assert property (FL_FAULT |=> !FL_FAULT) else $error("fault long");
  chk_fault_cause: assert property (
    FL_FAULT |-> FL_WRITE && !FL_WAIT && (FL_BYTEENABLE != 4'hf || FL_ADDR[1:0] != 2'h0))
    else $error("fault cause");
  chk_prog_time: assert property (
    FL_WRITE && !FL_WAIT |-> wcnt_q == 12'h1 || wcnt_q >= 12'h4e3) else $error("prog time");
  chk_data_read: assert property (
    FL_READ && !FL_FETCH && FL_WAIT |=> !FL_WAIT) else $error("data read stalled");
  chk_fetch_bound: assert property (
    FL_READ && FL_FETCH |-> ##[0:60] !FL_WAIT) else $error("fetch hung");
  chk_cfg_hold: assert property (
    $past(RST_N, 2) |-> $stable(USER_CFG_WORD)) else $error("cfg moved");
endmodule
`default_nettype wire

//--- nvc_cpu_model.sv
/* processor side of the flash port: one request at a time.
   assumes the stall output is combinational on the same clock. */
`timescale 1ns/100ps
`default_nettype none
module nvc_cpu_model
#(
  parameter int ADDR_W = 19
)
(
  // clock and stall
  input wire logic CLK,
  input wire logic FL_WAIT,
  // request
  output logic [ADDR_W-1:0] FL_ADDR,
  output logic FL_READ,
  output logic FL_WRITE,
  output logic FL_FETCH,
  output logic [31:0] FL_WDATA,
  output logic [3:0] FL_BYTEENABLE
);
  initial
  begin
    FL_ADDR = '0;
    FL_READ = 1'b0;
    FL_WRITE = 1'b0;
    FL_FETCH = 1'b0;
    FL_WDATA = 32'h0;
    FL_BYTEENABLE = 4'hf;
  end
  // byte enables and address as the caller gives them; a word may be written more than once between erases
  task automatic acc(input logic w, input logic f, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, input logic [3:0] be, input int gap, output logic ok);
    int n;
    repeat (gap + 1) @(posedge CLK);
    FL_ADDR <= a;
    FL_WDATA <= d;
    FL_BYTEENABLE <= be;
    FL_FETCH <= f;
    FL_WRITE <= w;
    FL_READ <= !w;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (FL_WAIT && n < 2000);
    ok = !FL_WAIT;
    FL_READ <= 1'b0;
    FL_WRITE <= 1'b0;
    FL_ADDR <= ~a;
    FL_WDATA <= ~d;
  endtask
endmodule
`default_nettype wire

//--- nvc_tb.sv
/* self-checking bench for nvc_flash_ctrl.
   shrunk array and erase counts; partner model drives the flash port. */
`timescale 1ns/100ps
`default_nettype none
module testbench
  import nvc_pkg::*;
();
  localparam int PEC = 20;
  localparam int FEC = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr = 12'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_rq;
  logic [18:0] fa;
  logic frd;
  logic fwr;
  logic ffe;
  logic fwt;
  logic fft;
  logic [31:0] fwd;
  logic [31:0] frdata;
  logic [31:0] ucfg;
  logic [3:0] fbe;
  logic [31:0] exp_q[$];
  logic [31:0] s = 32'h44;
  logic [31:0] r1;
  logic [31:0] r2;
  logic ok;
  int n_errors = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  nvc_flash_ctrl #(.PAGES(2), .PAGE_WORDS(4), .UCFG_WORDS(2), .PAGE_ERASE_CYCLES(PEC),
    .FULL_ERASE_CYCLES(FEC)) u_nvc_flash_ctrl (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq), .FL_ADDR(fa), .FL_READ(frd),
    .FL_WRITE(fwr), .FL_FETCH(ffe), .FL_WDATA(fwd), .FL_BYTEENABLE(fbe), .FL_RDATA(frdata),
    .FL_WAIT(fwt), .FL_FAULT(fft), .USER_CFG_WORD(ucfg));
  nvc_cpu_model u_nvc_cpu_model (.CLK(clk), .FL_WAIT(fwt), .FL_ADDR(fa), .FL_READ(frd),
    .FL_WRITE(fwr), .FL_FETCH(ffe), .FL_WDATA(fwd), .FL_BYTEENABLE(fbe));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic results();
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // results leave in order; take the oldest note
  always @(posedge clk)
    if ((rd && !wait_rq) || ((frd || fwr) && !fwt))
      chk(rd ? "reg" : fwr ? "fault" : "flash", exp_q.pop_front(),
        rd ? rdata : fwr ? {31'h0, fft} : frdata);
  // flash port stays idle while a command starts, as with a halted core
  task automatic avs(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_rq && n < 20);
    wr <= 1'b0;
    rd <= 1'b0;
    if (wait_rq)
    begin
      n_errors++;
      results();
    end
  endtask
  task automatic rreg(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    avs(1'b0, a, 32'h0);
  endtask
  task automatic fl(input logic w, input logic f, input logic [18:0] a, input logic [31:0] d,
    input logic [3:0] be, input logic [31:0] e);
    exp_q.push_back(e);
    u_nvc_cpu_model.acc(w, f, a, d, be, int'(rnd() % 4), ok);
    if (!ok)
    begin
      n_errors++;
      results();
    end
  endtask
  // busy just before the count ends, ready just after
  task automatic ers(input logic [11:0] a, input logic [31:0] d, input int t);
    avs(1'b1, a, d);
    repeat (t - 4) @(posedge clk);
    rreg(12'h400, 32'h0);
    repeat (3) @(posedge clk);
    rreg(12'h400, 32'h1);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rreg(12'h400, 32'h1);
    rreg(12'h504, 32'h0);
    avs(1'b1, 12'h600, 32'h2);
    rreg(12'h600, 32'h0);
    for (int m = 0; m < 3; m++)
    begin
      avs(1'b1, 12'h504, 32'(m));
      rreg(12'h504, 32'(m));
    end
    ers(12'h50c, 32'h1, FEC);
    fl(1'b0, 1'b0, 19'h10, 32'h0, 4'hf, 32'hffffffff);
    fl(1'b0, 1'b0, 19'h40004, 32'h0, 4'hf, 32'hffffffff);
    r1 = rnd();
    r2 = rnd();
    avs(1'b1, 12'h504, 32'h0);
    fl(1'b1, 1'b0, 19'h10, r1, 4'hf, 32'h0);
    fl(1'b0, 1'b0, 19'h10, 32'h0, 4'hf, 32'hffffffff);
    avs(1'b1, 12'h504, 32'h1);
    fl(1'b1, 1'b0, 19'h10, r1, 4'hf, 32'h0);
    fl(1'b1, 1'b0, 19'h10, r2, 4'hf, 32'h0);
    fl(1'b0, 1'b0, 19'h10, 32'h0, 4'hf, r1 & r2);
    fl(1'b1, 1'b0, 19'h0, r2, 4'hf, 32'h0);
    fl(1'b1, 1'b0, 19'h40000, r1, 4'hf, 32'h0);
    fl(1'b1, 1'b0, 19'h5, r2, 4'hf, 32'h1);
    fl(1'b1, 1'b0, 19'h4, r2, 4'h3, 32'h1);
    fl(1'b0, 1'b0, 19'h4, 32'h0, 4'hf, 32'hffffffff);
    avs(1'b1, 12'h508, 32'h0);
    rreg(12'h400, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("cfg", r1, ucfg);
    avs(1'b1, 12'h504, 32'h2);
    ers(12'h508, 32'h0, PEC);
    fl(1'b0, 1'b1, 19'h0, 32'h0, 4'hf, 32'hffffffff);
    fl(1'b0, 1'b0, 19'h10, 32'h0, 4'hf, r1 & r2);
    avs(1'b1, 12'h514, 32'h1);
    fl(1'b0, 1'b0, 19'h10, 32'h0, 4'hf, r1 & r2);
    fl(1'b0, 1'b1, 19'h40000, 32'h0, 4'hf, 32'hffffffff);
    rreg(12'h400, 32'h1);
    avs(1'b1, 12'h504, 32'h0);
    repeat (2) @(posedge clk);
    chk("notes left", 32'h0, 32'(exp_q.size()));
    results();
  end
endmodule
bind nvc_flash_ctrl nvc_flash_chk #(.ADDR_W(ADDR_W)) u_nvc_flash_chk (.CLK, .RST_N,
  .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .FL_ADDR, .FL_READ,
  .FL_WRITE, .FL_FETCH, .FL_BYTEENABLE, .FL_WAIT, .FL_FAULT, .USER_CFG_WORD);
`default_nettype wire
